// ==== hdl/cvsdd_pkg.sv ====
package cvsdd_pkg;
   // ==========================================
   // Sample stream and word widths
   localparam int SAMPLE_W       = 13;
   localparam int STEP_W         = 13;
   localparam int OVERLOAD_LEN   = 4;
   // ==========================================
   // Timing: sample clock and syllabic time constant
   localparam int SAMPLE_RATE_HZ = 64000;
   localparam int SYL_TC_MS      = 16;
   // Samples per time constant, rounded down
   localparam int SYL_TC_SAMPLES = SAMPLE_RATE_HZ * SYL_TC_MS / 1000;
   // Leak shifts: syllabic leak near 1/1024 per sample (about one time constant)
   localparam int SYL_LEAK_SH    = 10;
   localparam int PRI_LEAK_SH    = 8;
   // Growth per overloaded sample, as a fraction of full scale
   localparam int SYL_GROW_SH    = 5;
   // ==========================================
   // Limits and reset values
   localparam logic [12:0] STEP_MIN   = 13'h0010;
   localparam logic [12:0] STEP_MAX   = 13'h0FFF;
   localparam logic [12:0] STEP_RST   = 13'h0010;
   localparam logic [12:0] SAMPLE_RST = 13'h0000;
   localparam logic [3:0]  HIST_RST   = 4'h5;
   // ==========================================
   // Output buffer
   localparam int BUF_DEPTH = 2;
endpackage

// ==== hdl/cvsdd_skid_buf.sv ====
// Two-entry buffer: stall on the output side loses no word
module cvsdd_skid_buf (
   // Clock and reset
   input  wire logic                          clk_in,
   input  wire logic                          resetn_in,
   // Write side
   input  wire logic                          wr_valid_in,
   output logic                               wr_ready_out,
   input  wire logic [cvsdd_pkg::SAMPLE_W-1:0] wr_data_in,
   // Read side
   output logic                               rd_valid_out,
   input  wire logic                          rd_ready_in,
   output logic [cvsdd_pkg::SAMPLE_W-1:0]     rd_data_out
);
   // ==========================================
   // Storage
   logic [cvsdd_pkg::SAMPLE_W-1:0] mem_reg [cvsdd_pkg::BUF_DEPTH];
   logic                           wp_reg;
   logic                           rp_reg;
   logic [1:0]                     cnt_reg;
   wire                            push;
   wire                            pop;

   assign wr_ready_out = (cnt_reg != 2'h2);
   assign rd_valid_out = (cnt_reg != 2'h0);
   assign push         = wr_valid_in && wr_ready_out;
   assign pop          = rd_valid_out && rd_ready_in;
   assign rd_data_out  = mem_reg[rp_reg];

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         wp_reg  <= 1'b0;
         rp_reg  <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         if (push) wp_reg <= ~wp_reg;
         if (pop)  rp_reg <= ~rp_reg;
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge clk_in) begin
      if (push) mem_reg[wp_reg] <= wr_data_in;
   end
endmodule

// ==== hdl/cvsdd_decoder.sv ====
// How it works
// - Take one coded bit per sample clock
// - Two leaky integrators driven by current bit
// - Overload when last four bits match
// - Overload grows step, otherwise step decays
// - Step saturates; decay rate from 16 ms constant
// - Bit one adds step, zero subtracts
// - Output 13-bit sample word to DAC
module cvsdd_decoder (
   // Clock and reset
   input  wire logic                          clk_in,
   input  wire logic                          resetn_in,
   // Coded bit stream from demodulator
   input  wire logic                          bit_valid_in,
   output logic                               bit_ready_out,
   input  wire logic                          bit_in,
   // Sample words to the DAC
   output logic                               sample_valid_out,
   input  wire logic                          sample_ready_in,
   output logic [cvsdd_pkg::SAMPLE_W-1:0]     sample_out,
   // Status
   output logic                               overload_out,
   output logic [cvsdd_pkg::STEP_W-1:0]       step_out
);
   // ==========================================
   // Data flow per taken bit:
   //   history -> overload flag -> new step -> signed delta
   //   old sample -> leak -> plus delta -> clamp -> buffer
   // Everything between the bit port and the buffer is combinational,
   // so each sample word is stored in the buffer at the clock edge that takes its bit.

   // ==========================================
   // Internal widths
   // Two extra bits carry the sign and the carry of a 13-bit sum
   localparam int WIDE_W = cvsdd_pkg::SAMPLE_W + 2;
   localparam int HIST_W = cvsdd_pkg::OVERLOAD_LEN;
   // Limits of the signed sample word at the wide width; 7000 is -4096
   localparam logic signed [WIDE_W-1:0] WIDE_MAX = 15'sh0FFF;
   localparam logic signed [WIDE_W-1:0] WIDE_MIN = 15'sh7000;

   // ==========================================
   // State and next-state terms
   logic        [HIST_W-1:0]              hist_reg;
   wire         [HIST_W-1:0]              hist_next;
   logic        [cvsdd_pkg::STEP_W-1:0]   step_reg;
   wire         [cvsdd_pkg::STEP_W-1:0]   step_next;
   logic signed [cvsdd_pkg::SAMPLE_W-1:0] acc_reg;
   wire  signed [cvsdd_pkg::SAMPLE_W-1:0] acc_next;
   logic                                  ovl_reg;
   wire                                   ovl_now;
   // Handshake between the bit port and the output buffer
   logic                                  buf_ready;
   wire                                   take;

   // ==========================================
   // Helper functions

   // Saturate a wide signed sum into the signed sample range
   function automatic logic signed [cvsdd_pkg::SAMPLE_W-1:0] sat13(
      input logic signed [WIDE_W-1:0] v
   );
      logic signed [cvsdd_pkg::SAMPLE_W-1:0] r;
      if (v > WIDE_MAX) begin
         r = WIDE_MAX[cvsdd_pkg::SAMPLE_W-1:0];
      end else if (v < WIDE_MIN) begin
         r = WIDE_MIN[cvsdd_pkg::SAMPLE_W-1:0];
      end else begin
         r = v[cvsdd_pkg::SAMPLE_W-1:0];
      end
      return r;
   endfunction

   // Leak by a right-shifted fraction of the value itself; the
   // arithmetic shift keeps the sign of a negative value
   function automatic logic signed [WIDE_W-1:0] leak(
      input logic signed [WIDE_W-1:0] v,
      input int                       sh
   );
      return v - (v >>> sh);
   endfunction

   // Step after growth: stop at the ceiling instead of wrapping
   function automatic logic [cvsdd_pkg::STEP_W-1:0] step_ceil(
      input logic signed [WIDE_W-1:0] v
   );
      logic [cvsdd_pkg::STEP_W-1:0] r;
      if (v > $signed({2'b00, cvsdd_pkg::STEP_MAX})) begin
         r = cvsdd_pkg::STEP_MAX;
      end else begin
         r = v[cvsdd_pkg::STEP_W-1:0];
      end
      return r;
   endfunction

   // Step after decay: never fall below the floor
   function automatic logic [cvsdd_pkg::STEP_W-1:0] step_floor(
      input logic signed [WIDE_W-1:0] v
   );
      logic [cvsdd_pkg::STEP_W-1:0] r;
      if (v < $signed({2'b00, cvsdd_pkg::STEP_MIN})) begin
         r = cvsdd_pkg::STEP_MIN;
      end else begin
         r = v[cvsdd_pkg::STEP_W-1:0];
      end
      return r;
   endfunction

   // True when every bit of the history agrees
   function automatic logic all_same(input logic [HIST_W-1:0] h);
      logic ones;
      logic zeros;
      ones  = &h;
      zeros = ~|h;
      return ones || zeros;
   endfunction

   // ==========================================
   // Bit handshake
   // A bit is consumed only when the buffer can hold its sample, so a
   // stalled converter holds the demodulator back instead of losing audio
   assign take          = bit_valid_in && buf_ready;
   assign bit_ready_out = buf_ready;

   // ==========================================
   // Bit history: the newest bit enters at position zero
   assign hist_next[0] = bit_in;
   for (genvar i = 1; i < HIST_W; i++) begin : g_hist
      assign hist_next[i] = hist_reg[i-1];
   end

   // ==========================================
   // Overload detect on the newest four bits, the one taken now included
   assign ovl_now = all_same(hist_next);

   // ==========================================
   // Syllabic integrator: grow on overload, leak otherwise
   // Growth is a fixed fraction of full scale per overloaded sample; the
   // leak removes about one part in 1024 per sample, plus one so that a
   // small step still decays to the floor instead of stalling.
   // Limitation: the rates assume one bit is taken per sample period; a
   // faster bit rate would shorten the syllabic time constant.
   wire signed [WIDE_W-1:0]        step_w    = $signed({2'b00, step_reg});
   wire signed [WIDE_W-1:0]        grow_amt  =
      $signed({2'b00, cvsdd_pkg::STEP_MAX >> cvsdd_pkg::SYL_GROW_SH});
   wire signed [WIDE_W-1:0]        step_grow = step_w + grow_amt;
   wire signed [WIDE_W-1:0]        step_leak = leak(step_w, cvsdd_pkg::SYL_LEAK_SH) - 15'sh0001;
   wire [cvsdd_pkg::STEP_W-1:0]    step_up   = step_ceil(step_grow);
   wire [cvsdd_pkg::STEP_W-1:0]    step_dn   = step_floor(step_leak);
   assign step_next = ovl_now ? step_up : step_dn;

   // ==========================================
   // Principal integrator: leak, then add or subtract the new step
   // The step chosen for this sample applies at once, so a burst of
   // equal bits reacts without one sample of lag
   wire signed [WIDE_W-1:0] acc_w    = WIDE_W'(acc_reg);
   wire signed [WIDE_W-1:0] acc_leak = leak(acc_w, cvsdd_pkg::PRI_LEAK_SH);
   wire signed [WIDE_W-1:0] step_x   = $signed({2'b00, step_next});
   wire signed [WIDE_W-1:0] delta    = bit_in ? step_x : -step_x;
   wire signed [WIDE_W-1:0] acc_sum  = acc_leak + delta;
   assign acc_next = sat13(acc_sum);

   // ==========================================
   // Registers: one short process per register (history, step, integrator value, overload flag)
   // Nothing but the output buffer moves without a take, so a stall freezes history, step, integrator and flag
   // Shift history
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         hist_reg <= cvsdd_pkg::HIST_RST;
      end else if (take) begin
         hist_reg <= hist_next;
      end
   end

   // Step size
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         step_reg <= cvsdd_pkg::STEP_RST;
      end else if (take) begin
         step_reg <= step_next;
      end
   end

   // Principal integrator value
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         acc_reg <= cvsdd_pkg::SAMPLE_RST;
      end else if (take) begin
         acc_reg <= acc_next;
      end
   end

   // Overload flag, registered for the status port
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         ovl_reg <= 1'b0;
      end else if (take) begin
         ovl_reg <= ovl_now;
      end
   end

   // ==========================================
   // Output buffer toward the DAC
   // It stores the clamped sum, so a word is ready one clock after its bit
   cvsdd_skid_buf u_buf (
      .clk_in       (clk_in),
      .resetn_in    (resetn_in),
      .wr_valid_in  (take),
      .wr_ready_out (buf_ready),
      .wr_data_in   (acc_next),
      .rd_valid_out (sample_valid_out),
      .rd_ready_in  (sample_ready_in),
      .rd_data_out  (sample_out)
   );

   // ==========================================
   // Status outputs straight from registers
   // The step shown is the one applied to the last taken bit
   assign overload_out = ovl_reg;
   assign step_out     = step_reg;
endmodule

// ==== tb/cvsdd_demod_model.sv ====
module cvsdd_demod_model (
   // Clock, reset and pattern choice
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   input  wire logic [1:0] pat_in,
   // Coded bit handshake
   input  wire logic       ready_in,
   output logic            valid_out = 1'b1,
   output logic            bit_out = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] n = 8'h00;
   logic       tk = 1'b0;
   // Word held until taken; pattern 3 leaves gaps as a slow source
   always @(negedge clk_in) begin
      if (tk || !valid_out) begin
         n = n + 8'h01;
         valid_out = !(pat_in == 2'h3 && n[2:0] == 3'h7);
         bit_out = !valid_out ? ~bit_out
                 : pat_in[1] ? pat_in[0] && n[3] : pat_in[0] || n[0];
      end
      #20 tk = valid_out && ready_in && resetn_in;
   end
endmodule

// ==== tb/cvsdd_decoder_sva.sv ====
module cvsdd_decoder_sva (
   // Decoder ports
   input wire logic        clk_in,
   input wire logic        resetn_in,
   input wire logic        bit_valid_in,
   input wire logic        bit_ready_out,
   input wire logic        bit_in,
   input wire logic        sample_valid_out,
   input wire logic        sample_ready_in,
   input wire logic [12:0] sample_out,
   input wire logic        overload_out,
   input wire logic [12:0] step_out
);
   wire tk = bit_valid_in && bit_ready_out;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // ==========================================
   // Assertions
   a_bit_word: assert property (tk |=> sample_valid_out) else $error("word missing");
   a_full_valid: assert property
      (!bit_ready_out |-> sample_valid_out) else $error("bad refusal");
   a_word_holds: assert property
      (sample_valid_out && !sample_ready_in |=> $stable(sample_out)) else $error("word moved");
   a_run_overload: assert property
      ((tk && bit_in) [*4] |=> overload_out) else $error("no overload");
   a_mix_clear: assert property
      ((tk && bit_in) ##1 (tk && !bit_in) |=> !overload_out) else $error("false overload");
   a_step_dir: assert property (tk |=> (overload_out ? step_out >= $past(step_out)
      : step_out <= $past(step_out))) else $error("step direction");
   a_idle_hold: assert property
      (!tk |=> $stable(step_out) && $stable(overload_out)) else $error("moved without bit");
   a_step_limits: assert property
      (step_out >= 13'h0010 && step_out <= 13'h0FFF) else $error("step range");
   // ==========================================
   // Covers
   c_step_top: cover property (overload_out && step_out == 13'h0FFF);
   c_full: cover property (!bit_ready_out);
   c_floor: cover property (sample_valid_out && sample_ready_in && sample_out == 13'h1000);
endmodule
bind cvsdd_decoder cvsdd_decoder_sva i_sva (.clk_in, .resetn_in, .bit_valid_in, .bit_ready_out,
   .bit_in, .sample_valid_out, .sample_ready_in, .sample_out, .overload_out, .step_out);

// ==== tb/tb_top.sv ====
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_in = 0, resetn_in = 0, sample_ready_in = 1;
   logic        bit_valid_in, bit_in, bit_ready_out, sample_valid_out, overload_out;
   logic [12:0] sample_out, step_out;
   logic [1:0]  pat = 2'h0;
   logic [12:0] q[$];
   int          failures = 0, checked = 0, cyc = 0, hist, stp, acc, ovl;
   always #25 clk_in = ~clk_in;
   cvsdd_demod_model i_dem (.clk_in, .resetn_in, .pat_in(pat), .ready_in(bit_ready_out),
      .valid_out(bit_valid_in), .bit_out(bit_in));
   cvsdd_decoder i_dut (.clk_in, .resetn_in, .bit_valid_in, .bit_ready_out, .bit_in,
      .sample_valid_out, .sample_ready_in, .sample_out, .overload_out, .step_out);
   task cmp(string n, logic [12:0] e, logic [12:0] s);
      checked++;
      if (e !== s) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task cmp_flag(string n, logic e, logic s);
      checked++;
      if (e !== s) begin
         failures++;
         $display("Error %s expected %b seen %b", n, e, s);
      end
   endtask
   // ==========================================
   // Reference, sampled just before each rising edge
   always @(negedge clk_in) begin
      #20;
      if (!resetn_in) begin
         hist = 5; stp = 16; acc = 0; ovl = 0; q.delete();
      end else begin
         cmp("step_out", stp, step_out);
         cmp_flag("overload_out", ovl != 0, overload_out);
         cmp_flag("sample_valid_out", q.size() != 0, sample_valid_out);
         cmp_flag("bit_ready_out", q.size() != 2, bit_ready_out);
         if (sample_valid_out && sample_ready_in) begin
            cmp("sample_out", q.pop_front(), sample_out);
         end
         if (bit_valid_in && bit_ready_out) begin
            hist = ((hist << 1) | bit_in) & 15;
            ovl = hist == 0 || hist == 15;
            stp = ovl ? stp + 127 : stp - (stp >> 10) - 1;
            stp = stp > 4095 ? 4095 : stp < 16 ? 16 : stp;
            acc = acc - (acc >>> 8) + (bit_in ? stp : -stp);
            acc = acc > 4095 ? 4095 : acc < -4096 ? -4096 : acc;
            q.push_back(acc[12:0]);
         end
      end
   end
   always @(posedge clk_in) if (++cyc == 2000) begin
      failures++;
      results();
   end
   task results;
      if (failures == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task t_run(logic [1:0] p, int n);
      pat = p;
      repeat (n) @(negedge clk_in);
   endtask
   task t_alternate;
      t_run(2'h0, 80);
   endtask
   // Long runs push step into its ceiling and sample into both clamps
   task t_overload;
      t_run(2'h1, 60);
      t_run(2'h2, 70);
   endtask
   task t_stall;
      sample_ready_in = 0;
      t_run(2'h3, 6);
      cmp_flag("bit_ready_out", 1'b0, bit_ready_out);
      sample_ready_in = 1;
      t_run(2'h3, 40);
   endtask
   task t_reset;
      resetn_in = 0;
      t_run(2'h0, 2);
      resetn_in = 1;
      t_run(2'h3, 30);
   endtask
   initial begin
      repeat (8) @(negedge clk_in);
      resetn_in = 1;
      t_alternate();
      t_overload();
      t_stall();
      t_reset();
      results();
   end
endmodule
